// *** src/adc_pin_pkg.sv ***
// shared constants for the converter pin-level control block
package adc_pin_pkg;
  localparam int unsigned CLK_MHZ          = 200;        // mclk rate
  localparam int unsigned SCLK_MAX_KHZ     = 5000;       // serial clock ceiling, 5MHz
  localparam int unsigned WORD_BITS        = 16;         // result word width
  localparam int unsigned CNT_W            = 5;          // bit counter width
  localparam int unsigned REF_DIV_FAST     = 64;         // reference sampling divisor
  localparam int unsigned REF_DIV_SLOW     = 128;        // halved-clock reference divisor
  localparam int unsigned MOD_DIV          = 128;        // modulator sampling divisor
  localparam int unsigned DIV_W            = 8;          // divider counter width
  localparam int unsigned RATE_MIN_HZ      = 20;         // slowest output rate
  localparam int unsigned RATE_MAX_HZ      = 500;        // fastest output rate
  localparam int unsigned OSC_LOW_KHZ      = 1000;       // on-chip oscillator, 1MHz
  localparam int unsigned OSC_HIGH_HZ      = 2457600;    // on-chip oscillator, 2.4576MHz
  localparam logic [15:0] BIPOLAR_FLIP     = 16'h8000;   // offset binary sign flip
  localparam logic [2:0]  GAIN_CODE_MAX    = 3'h7;       // gain 128
  typedef enum logic [1:0]
  {
    RATE_LOW  = 2'b00,
    RATE_MID  = 2'b01,
    RATE_HIGH = 2'b10,
    RATE_TOP  = 2'b11
  } rate_code_t;
endpackage

// *** src/result_store.sv ***
// one-word result holding register with registered read data
`timescale 1ns/100ps
module result_store
#(
  parameter int unsigned WIDTH = 16
)
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             srst,
  // write side
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side
  output logic      [WIDTH-1:0] rd_data
);
  // store a new conversion result, clear on reset
  always_ff @(posedge mclk)
  begin
    if (srst)
      rd_data <= '0;
    else if (wr_en)
      rd_data <= wr_data;
  end
endmodule

// *** src/sigma_delta_adc_pin_control.sv ***
// pin-level control of a two-channel sigma-delta converter
//
// Contract
// - serial clock comes from outside; transfers work up to 5MHz.
// - oscillator clock output driven only while osc_out_disable is 0.
// - enabled oscillator output is the inverse of the master clock.
// - transfers happen only while chip select is low.
// - serial_out_pin floats whenever chip select is high.
// - reset input low returns all logic to power-on state.
// - result_ready_n falls when a new result enters the data register.
// - result_ready_n rises after the host reads the whole word.
// - output changes on falling serial clock; host samples on rising.
// - input captured on rising serial clock while chip select low.
// - gains 1 to 128 chosen by three gain code bits.
// - input isolation buffer follows input_isolation_enable.
// - reference sampled at master clock over 64, or 128 when halved; stays 64 with the on-chip oscillator.
// - output data rate programmable from 20Hz to 500Hz.
// - modulator samples at master clock over 128 at every gain.
// - on-chip oscillator 1MHz or 2.4576MHz by rate_select_bit; halve ignored.
// - unipolar gives straight binary, bipolar gives offset binary.
// - rate bits and rate_select_bit set cutoff and output rate.
`timescale 1ns/100ps
module sigma_delta_adc_pin_control
  import adc_pin_pkg::*;
#(
  parameter int unsigned WORD_W = adc_pin_pkg::WORD_BITS
)
(
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic                     reset_n,
  // master clock and oscillator output
  input  wire logic                     master_clock_in,
  input  wire logic                     osc_out_disable,
  output logic                          oscillator_clock_out,
  output logic                          oscillator_clock_oe,
  // serial port pins, sampled on mclk
  input  wire logic                     sclk_pin,
  input  wire logic                     chip_select_n,
  input  wire logic                     serial_in_pin,
  output logic                          serial_out_pin,
  output logic                          serial_out_oe,
  output logic                          result_ready_n,
  // conversion result from the filter
  input  wire logic                     result_valid,
  input  wire logic [WORD_W-1:0]        result_raw,
  // setup bits
  input  wire logic [2:0]               gain_code,
  input  wire logic                     input_isolation_enable,
  input  wire logic                     polarity_select,
  // clock bits
  input  wire logic                     input_clock_halve,
  input  wire logic                     onchip_osc_select,
  input  wire logic                     rate_select_bit,
  input  wire logic                     rate_code_bit0,
  input  wire logic                     rate_code_bit1,
  // analog control outputs
  output logic [7:0]                    gain_factor,
  output logic                          buffer_enable,
  output logic                          ref_sample_strobe,
  output logic                          mod_sample_strobe,
  output logic                          osc_high_select,
  output logic [1:0]                    rate_sel,
  // received serial data
  output logic [WORD_W-1:0]             rx_word,
  output logic                          rx_word_valid
);
  import adc_pin_pkg::*;

  // -------------------------------------------------
  // helpers
  // -------------------------------------------------
  // gain code to gain factor, one-hot power of two
  function automatic logic [7:0] gain_of(input logic [2:0] code);
    gain_of = 8'h01 << code;
  endfunction

  logic              rst;
  logic              sclk_q;
  logic              sclk_rise;
  logic              sclk_fall;
  logic [CNT_W-1:0]  tx_cnt_reg;
  logic [CNT_W-1:0]  rx_cnt_reg;
  logic [WORD_W-1:0] tx_shift_reg;
  logic [WORD_W-1:0] rx_shift_reg;
  logic [WORD_W-1:0] data_word;
  logic [WORD_W-1:0] coded_word;
  logic [DIV_W-1:0]  ref_div_reg;
  logic [DIV_W-1:0]  mod_div_reg;
  logic [DIV_W-1:0]  ref_limit;
  logic              word_done;

  // reset from either the system or the pin
  assign rst = srst | ~reset_n;

  // -------------------------------------------------
  // oscillator output
  // -------------------------------------------------
  // inverted master clock, driven only when enabled
  assign oscillator_clock_out = ~master_clock_in;
  assign oscillator_clock_oe  = ~osc_out_disable;

  // -------------------------------------------------
  // setup and clock bits
  // -------------------------------------------------
  assign gain_factor     = gain_of(gain_code);
  assign buffer_enable   = input_isolation_enable;
  assign osc_high_select = rate_select_bit;
  assign rate_sel        = {rate_code_bit1, rate_code_bit0};

  // reference divisor; halve ignored with on-chip oscillator
  assign ref_limit = (input_clock_halve && !onchip_osc_select)
                     ? DIV_W'(REF_DIV_SLOW - 1) : DIV_W'(REF_DIV_FAST - 1);

  // reference sampling divider
  always_ff @(posedge mclk)
  begin
    if (rst)
      ref_div_reg <= '0;
    else if (ref_div_reg >= ref_limit)
      ref_div_reg <= '0;
    else
      ref_div_reg <= DIV_W'(ref_div_reg + 1'b1);
  end
  assign ref_sample_strobe = (ref_div_reg >= ref_limit);

  // modulator divider, independent of gain
  always_ff @(posedge mclk)
  begin
    if (rst)
      mod_div_reg <= '0;
    else if (mod_div_reg == DIV_W'(MOD_DIV - 1))
      mod_div_reg <= '0;
    else
      mod_div_reg <= DIV_W'(mod_div_reg + 1'b1);
  end
  assign mod_sample_strobe = (mod_div_reg == DIV_W'(MOD_DIV - 1));

  // -------------------------------------------------
  // result register and ready flag
  // -------------------------------------------------
  // offset binary for bipolar, straight for unipolar
  assign coded_word = polarity_select ? (result_raw ^ WORD_W'(BIPOLAR_FLIP))
                                      : result_raw;

  result_store #(.WIDTH(WORD_W)) u_store
  (
    .mclk    (mclk),
    .srst    (rst),
    .wr_en   (result_valid),
    .wr_data (coded_word),
    .rd_data (data_word)
  );

  assign word_done = sclk_rise && !chip_select_n && rx_cnt_reg == CNT_W'(WORD_W - 1);

  // ready low on new result; set wins over the read completion
  always_ff @(posedge mclk)
  begin
    if (rst)
      result_ready_n <= 1'b1;
    else if (result_valid)
      result_ready_n <= 1'b0;
    else if (word_done)
      result_ready_n <= 1'b1;
  end

  // -------------------------------------------------
  // serial port
  // -------------------------------------------------
  // serial clock edge detection on mclk
  always_ff @(posedge mclk)
  begin
    if (rst)
      sclk_q <= 1'b1;
    else
      sclk_q <= sclk_pin;
  end
  assign sclk_rise = sclk_pin & ~sclk_q;
  assign sclk_fall = ~sclk_pin & sclk_q;

  // output shifter, loads the data register at word start
  always_ff @(posedge mclk)
  begin
    if (rst || chip_select_n)
    begin
      tx_cnt_reg   <= '0;
      tx_shift_reg <= '0;
    end
    else if (sclk_fall)
    begin
      if (tx_cnt_reg == '0)
        tx_shift_reg <= data_word;
      else
        tx_shift_reg <= {tx_shift_reg[WORD_W-2:0], 1'b0};
      tx_cnt_reg <= (tx_cnt_reg == CNT_W'(WORD_W - 1)) ? '0 : CNT_W'(tx_cnt_reg + 1'b1);
    end
  end
  assign serial_out_pin = tx_shift_reg[WORD_W-1];
  assign serial_out_oe  = ~chip_select_n;

  // input shifter on rising edges while selected
  always_ff @(posedge mclk)
  begin
    if (rst || chip_select_n)
    begin
      rx_cnt_reg   <= '0;
      rx_shift_reg <= '0;
    end
    else if (sclk_rise)
    begin
      rx_shift_reg <= {rx_shift_reg[WORD_W-2:0], serial_in_pin};
      rx_cnt_reg   <= (rx_cnt_reg == CNT_W'(WORD_W - 1)) ? '0 : CNT_W'(rx_cnt_reg + 1'b1);
    end
  end

  // completed received word
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rx_word       <= '0;
      rx_word_valid <= 1'b0;
    end
    else
    begin
      rx_word_valid <= word_done;
      if (word_done)
        rx_word <= {rx_shift_reg[WORD_W-2:0], serial_in_pin};
    end
  end

  // -------------------------------------------------
  // assertions
  // -------------------------------------------------
  chk_ready_on_result: assert property (@(posedge mclk) disable iff (rst)
    result_valid |=> !result_ready_n) else $error("ready not low after result");
  chk_ready_on_read: assert property (@(posedge mclk) disable iff (rst)
    word_done && !result_valid |=> result_ready_n) else $error("ready not high after read");
  chk_out_float: assert property (@(posedge mclk) disable iff (rst)
    chip_select_n |-> !serial_out_oe) else $error("output driven while deselected");
  chk_osc_enable: assert property (@(posedge mclk) disable iff (rst)
    osc_out_disable |-> !oscillator_clock_oe) else $error("osc out driven while disabled");
  chk_osc_invert: assert property (@(posedge mclk) disable iff (rst)
    oscillator_clock_out != master_clock_in) else $error("osc out not inverted");
  chk_gain_map: assert property (@(posedge mclk) disable iff (rst)
    gain_factor == (8'h01 << gain_code)) else $error("gain map wrong");
  chk_mod_period: assert property (@(posedge mclk) disable iff (rst)
    mod_sample_strobe |=> !mod_sample_strobe [*8]) else $error("modulator strobe too soon");
  chk_bipolar_code: assert property (@(posedge mclk) disable iff (rst)
    result_valid && polarity_select |=> data_word == ($past(result_raw) ^ WORD_W'(BIPOLAR_FLIP)))
    else $error("bipolar code wrong");
  chk_rx_idle: assert property (@(posedge mclk) disable iff (rst)
    chip_select_n |=> rx_cnt_reg == '0) else $error("receive count moved while deselected");
  chk_reset_ready: assert property (@(posedge mclk)
    rst |=> result_ready_n) else $error("ready low after reset");
  cov_result: cover property (@(posedge mclk) disable iff (rst) result_valid);
  cov_word_read: cover property (@(posedge mclk) disable iff (rst) word_done);
  cov_ref_strobe: cover property (@(posedge mclk) disable iff (rst) ref_sample_strobe);
endmodule

// *** verification/spi_host_model.sv ***
// serial bus master model facing the converter's serial port
`timescale 1ns/100ps
module spi_host_model
(
  // clock
  input  wire logic mclk,
  // serial pins
  output logic      sclk_pin,
  output logic      chip_select_n,
  output logic      serial_in_pin,
  input  wire logic serial_out_pin
);
  // idle bus: deselected, serial clock parked high
  initial
  begin
    sclk_pin      = 1'b1;
    chip_select_n = 1'b1;
    serial_in_pin = 1'b0;
  end

  // one transfer, msb first; half is the clock phase in mclk cycles
  // keep leaves the port selected afterwards, as in three-wire use
  task automatic xfer(input logic [15:0] tx, input int half, input int nbits,
                      output logic [15:0] rx, input bit keep);
    rx = 16'h0000;
    @(posedge mclk) chip_select_n <= 1'b0;
    repeat (half) @(posedge mclk);
    for (int i = 0; i < nbits; i++)
    begin
      sclk_pin      <= 1'b0;
      serial_in_pin <= tx[15-i];
      repeat (half) @(posedge mclk);
      sclk_pin <= 1'b1;
      rx       = {rx[14:0], serial_out_pin};
      repeat (half) @(posedge mclk);
    end
    // released data line shows the inverse, not the last bit
    if (!keep)
    begin
      chip_select_n <= 1'b1;
      serial_in_pin <= ~serial_in_pin;
    end
    @(posedge mclk);
  endtask
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the converter pin-level control block
`timescale 1ns/100ps
module testbench;
  import adc_pin_pkg::*;
  logic mclk, srst, reset_n, master_clock_in, osc_out_disable, oscillator_clock_out;
  logic oscillator_clock_oe, sclk_pin, chip_select_n, serial_in_pin, serial_out_pin;
  logic serial_out_oe, result_ready_n, result_valid, input_isolation_enable;
  logic polarity_select, input_clock_halve, onchip_osc_select, rate_select_bit;
  logic rate_code_bit0, rate_code_bit1, buffer_enable, ref_sample_strobe;
  logic mod_sample_strobe, osc_high_select, rx_word_valid;
  logic [15:0] result_raw, rx_word, rx_seen;
  logic [7:0]  gain_factor;
  logic [2:0]  gain_code;
  logic [1:0]  rate_sel;
  int          n_mismatch = 0;
  int          n_checks = 0;

  sigma_delta_adc_pin_control u_sigma_delta_adc_pin_control (.mclk, .srst, .reset_n,
    .master_clock_in, .osc_out_disable, .oscillator_clock_out, .oscillator_clock_oe,
    .sclk_pin, .chip_select_n, .serial_in_pin, .serial_out_pin, .serial_out_oe,
    .result_ready_n, .result_valid, .result_raw, .gain_code, .input_isolation_enable,
    .polarity_select, .input_clock_halve, .onchip_osc_select, .rate_select_bit,
    .rate_code_bit0, .rate_code_bit1, .gain_factor, .buffer_enable, .ref_sample_strobe,
    .mod_sample_strobe, .osc_high_select, .rate_sel, .rx_word, .rx_word_valid);
  spi_host_model u_spi_host_model (.mclk, .sclk_pin, .chip_select_n, .serial_in_pin,
    .serial_out_pin);

  // 200 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // latch each received word
  always @(posedge mclk)
    if (rx_word_valid === 1'b1)
      rx_seen <= rx_word;

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // cycles from the next strobe to the one after it, bounded
  task automatic gap(input bit m, output int n);
    for (int s = 0; s < 2; s++)
    begin
      n = 0;
      do
      begin
        @(negedge mclk);
        n++;
        if (n > 300)
        begin
          n_mismatch++;
          print_verdict;
        end
      end
      while ((m ? mod_sample_strobe : ref_sample_strobe) !== 1'b1);
    end
  endtask

  task automatic t_osc;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk) {osc_out_disable, master_clock_in} <= i[1:0];
      @(negedge mclk);
      chk("osc out", !i[0], oscillator_clock_out);
      chk("osc oe", !i[1], oscillator_clock_oe);
    end
  endtask

  task automatic t_setup;
    for (int g = 0; g < 8; g++)
    begin
      @(posedge mclk) gain_code <= g[2:0];
      input_isolation_enable <= g[0];
      rate_select_bit <= g[1];
      {rate_code_bit1, rate_code_bit0} <= {g[2], g[0]};
      @(negedge mclk);
      chk("gain", 16'h0001 << g, gain_factor);
      chk("buffer", g[0], buffer_enable);
      chk("osc high", g[1], osc_high_select);
      chk("rate", {g[2], g[0]}, rate_sel);
    end
  endtask

  task automatic t_strobe;
    int n;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge mclk) input_clock_halve <= k > 0;
      onchip_osc_select <= k > 1;
      gap(0, n);
      chk("ref period", k == 1 ? 128 : 64, n);
      gap(1, n);
      chk("mod period", 128, n);
    end
  endtask

  task automatic new_result(logic [15:0] raw, logic pol);
    @(posedge mclk) result_valid <= 1'b1;
    result_raw <= raw;
    polarity_select <= pol;
    @(posedge mclk) result_valid <= 1'b0;
    @(negedge mclk) chk("ready_n", 0, result_ready_n);
  endtask

  task automatic t_read(logic [15:0] raw, logic pol, int half);
    logic [15:0] rx;
    new_result(raw, pol);
    u_spi_host_model.xfer(~raw, half, 16, rx, 1'b0);
    chk("dout word", pol ? raw ^ BIPOLAR_FLIP : raw, rx);
    repeat (3) @(negedge mclk);
    chk("ready_n", 1, result_ready_n);
    chk("din word", ~raw, rx_seen);
  endtask

  // three-wire use: select stays low across two whole words
  task automatic t_three_wire;
    logic [15:0] rx;
    new_result(16'h3C5A, 1'b0);
    u_spi_host_model.xfer(16'h0F0F, 4, 16, rx, 1'b1);
    chk("dout word", 16'h3C5A, rx);
    @(negedge mclk) chk("dout oe", 1, serial_out_oe);
    chk("ready_n", 1, result_ready_n);
    chk("din word", 16'h0F0F, rx_seen);
    new_result(16'h8001, 1'b1);
    u_spi_host_model.xfer(16'hF0F0, 4, 16, rx, 1'b0);
    chk("dout word", 16'h0001, rx);
    repeat (3) @(negedge mclk);
    chk("ready_n", 1, result_ready_n);
    chk("din word", 16'hF0F0, rx_seen);
  endtask

  task automatic t_abort;
    logic [15:0] rx;
    new_result(16'h1234, 1'b0);
    u_spi_host_model.xfer(16'h0000, 4, 8, rx, 1'b0);
    repeat (3) @(negedge mclk);
    chk("ready_n", 0, result_ready_n);
    chk("dout oe", 0, serial_out_oe);
    @(posedge mclk) reset_n <= 1'b0;
    @(posedge mclk) reset_n <= 1'b1;
    @(negedge mclk) chk("ready_n", 1, result_ready_n);
  endtask

  // main sequence
  initial
  begin
    {master_clock_in, osc_out_disable, result_valid, gain_code} = '0;
    {input_isolation_enable, polarity_select, input_clock_halve} = '0;
    {onchip_osc_select, rate_select_bit, rate_code_bit0, rate_code_bit1} = '0;
    result_raw = 16'h0000;
    reset_n = 1'b1;
    srst = 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk) chk("ready_n", 1, result_ready_n);
    chk("dout oe", 0, serial_out_oe);
    t_osc;
    t_setup;
    t_strobe;
    t_read(16'hA5C3, 1'b0, 20);
    t_read(16'h0001, 1'b1, 4);
    t_read(16'hFFFE, 1'b1, 4);
    t_three_wire;
    t_abort;
    t_read(16'h8000, 1'b0, 4);
    print_verdict;
  end
endmodule
